// ### pkg/dpw_if.sv
// dpw_if: command and data pins between controller and memory
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface dpw_if import dpw_pkg::*; (input wire logic clk);
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dq_wr;
  logic [DM_W-1:0] dm;
  logic [DQ_W-1:0] dq_rd;
  logic dq_rd_oe;
  logic rdqs;
  logic rdqs_oe;
  modport mem (input clk, cs_n, ras_n, cas_n, we_n, bank, addr, dq_wr, dm,
    output dq_rd, dq_rd_oe, rdqs, rdqs_oe);
  modport ctl (input clk, dq_rd, dq_rd_oe, rdqs, rdqs_oe,
    output cs_n, ras_n, cas_n, we_n, bank, addr, dq_wr, dm);
endinterface
`default_nettype wire

// ### pkg/dpw_pkg.sv
// dpw_pkg: shared constants for the ddr2 precharge/write-interrupt command link
// assumes a single 20 MHz clock shared by both ends
package dpw_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 14;
  localparam int AP_BIT = 10;
  localparam int DQ_W = 8;
  localparam int DM_W = DQ_W / 8;
  localparam int BL4 = 4;
  localparam int BL8 = 8;
  localparam int CNT_W = 8;
  localparam int INTR_GAP = 2;
  localparam int PREFETCH_GAP = 2;
  // analog times in ns and their clock counts (rounded up)
  localparam int TRAS_NS = 40;
  localparam int TRP_NS = 15;
  localparam int TRTP_NS = 8;
  localparam int TWR_NS = 15;
  localparam int TRC_NS = 55;
  localparam int TRAS_CK = (TRAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRP_CK = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRTP_CK = (TRTP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TWR_CK = (TWR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRC_CK = (TRC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // command encoding {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_DESEL = 4'h8;
endpackage

// ### rtl/dpw_ctl.sv
// dpw_ctl: controller end; issues one user command at a time honouring bank timing
// assumes the user holds req until ack; wdata/wmask presented per beat on wbeat
`timescale 1ns/1ps
`default_nettype none
module dpw_ctl import dpw_pkg::*; #(
  parameter int AL = 0,
  parameter int CL = 3
) (
  input wire logic clk,
  input wire logic rst,
  dpw_if.ctl c,
  input wire logic bl8,
  input wire logic req,
  input wire logic [3:0] req_cmd,
  input wire logic [BANK_W-1:0] req_bank,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic req_intr,
  output logic ack,
  input wire logic [DQ_W-1:0] wdata,
  input wire logic [DM_W-1:0] wmask,
  output logic wbeat,
  output logic [DQ_W-1:0] rdata,
  output logic rvalid
);
  localparam int WL = AL + CL - 1;
  logic [CNT_W-1:0] bl_half;
  assign bl_half = bl8 ? CNT_W'(BL8 / 2) : CNT_W'(BL4 / 2);

  // ------------------------------------------------------------
  // per-bank timers, whole clocks rounded up
  // ------------------------------------------------------------
  logic [CNT_W-1:0] pre_ok_r [NUM_BANKS];
  logic [CNT_W-1:0] act_ok_r [NUM_BANKS];
  logic [CNT_W-1:0] rc_ok_r [NUM_BANKS];
  logic [CNT_W-1:0] wgap_r;
  logic last_wr_ap_r;
  logic [CNT_W-1:0] since_wr_r;
  logic allowed;
  logic tgt_pre_ok, tgt_act_ok;
  always_comb begin
    tgt_pre_ok = 1'b1;
    tgt_act_ok = (act_ok_r[req_bank] == '0) && (rc_ok_r[req_bank] == '0); // see RQ21
    for (int b = 0; b < NUM_BANKS; b++) begin
      if ((req_addr[AP_BIT] || req_bank == BANK_W'(b)) && pre_ok_r[b] != '0) tgt_pre_ok = 1'b0;
    end
  end
  // write interrupt only at burst eight, no ap on the old write, exactly two clocks
  logic intr_ok;
  assign intr_ok = bl8 && !last_wr_ap_r && (since_wr_r == CNT_W'(INTR_GAP - 1)); // see RQ1 see RQ3 see RQ5
  always_comb begin
    case (req_cmd)
      CMD_ACT: allowed = tgt_act_ok; // see RQ13
      CMD_PRE: allowed = tgt_pre_ok && (wgap_r == '0); // see RQ2 see RQ12 see RQ15
      CMD_WR: allowed = req_intr ? intr_ok : (wgap_r == '0); // see RQ2 see RQ4 see RQ6
      CMD_RD: allowed = (wgap_r == '0);
      default: allowed = 1'b1;
    endcase
  end
  assign ack = req && allowed;

  logic [NUM_BANKS-1:0] bank_hit;
  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      bank_hit[b] = (req_bank == BANK_W'(b));
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        pre_ok_r[b] <= '0;
        act_ok_r[b] <= '0;
        rc_ok_r[b] <= '0;
      end
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (pre_ok_r[b] != '0) pre_ok_r[b] <= pre_ok_r[b] - 8'h01;
        if (act_ok_r[b] != '0) act_ok_r[b] <= act_ok_r[b] - 8'h01;
        if (rc_ok_r[b] != '0) rc_ok_r[b] <= rc_ok_r[b] - 8'h01;
        if (ack && bank_hit[b] && req_cmd == CMD_ACT) begin
          pre_ok_r[b] <= CNT_W'(TRAS_CK); // see RQ23
          rc_ok_r[b] <= CNT_W'(TRC_CK);
        end
        if (ack && bank_hit[b] && req_cmd == CMD_RD) begin
          // al+bl/2 and trtp from last prefetch, plus trp if auto-precharge
          pre_ok_r[b] <= CNT_W'(AL) + bl_half + CNT_W'(TRTP_CK); // see RQ14
          if (req_addr[AP_BIT]) act_ok_r[b] <= CNT_W'(AL) + bl_half + CNT_W'(TRTP_CK + TRP_CK); // see RQ20
        end
        if (ack && bank_hit[b] && req_cmd == CMD_WR) begin
          // programmed burst length, even when interrupted
          pre_ok_r[b] <= CNT_W'(WL) + bl_half + CNT_W'(TWR_CK); // see RQ7 see RQ15
          if (req_addr[AP_BIT]) act_ok_r[b] <= CNT_W'(WL) + bl_half + CNT_W'(TWR_CK + TRP_CK);
        end
        if (ack && req_cmd == CMD_PRE && (req_addr[AP_BIT] || bank_hit[b])) begin
          act_ok_r[b] <= CNT_W'(TRP_CK);
        end
      end
    end
  end

  // write spacing: a burst holds off read, precharge and plain write until bl/2 clocks after it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wgap_r <= '0;
      since_wr_r <= '1;
      last_wr_ap_r <= 1'b0;
    end else if (ack && req_cmd == CMD_WR) begin
      wgap_r <= bl_half - 8'h01;
      since_wr_r <= '0;
      last_wr_ap_r <= req_addr[AP_BIT];
    end else begin
      if (wgap_r != '0) wgap_r <= wgap_r - 8'h01;
      if (since_wr_r != '1) since_wr_r <= since_wr_r + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // pins and data
  // ------------------------------------------------------------
  localparam int SHW_C = 16;
  logic [SHW_C-1:0] wl_line_r;
  logic [CNT_W-1:0] wcnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {c.cs_n, c.ras_n, c.cas_n, c.we_n} <= CMD_NOP;
      c.bank <= '0;
      c.addr <= '0;
      c.dq_wr <= '0;
      c.dm <= '1;
      wl_line_r <= '0;
      wcnt_r <= '0;
      rdata <= '0;
      rvalid <= 1'b0;
    end else begin
      {c.cs_n, c.ras_n, c.cas_n, c.we_n} <= ack ? req_cmd : CMD_NOP;
      c.bank <= req_bank;
      c.addr <= req_addr;
      wl_line_r <= {wl_line_r[SHW_C-2:0], ack && req_cmd == CMD_WR};
      // beats are taken one clock ahead so the registered pins meet the memory at WL
      if (wl_line_r[WL-1]) wcnt_r <= bl_half << 1; // see RQ22
      else if (wcnt_r != '0) wcnt_r <= wcnt_r - 8'h01;
      c.dq_wr <= wdata;
      c.dm <= wbeat ? wmask : '1; // see RQ8
      rdata <= c.dq_rd;
      rvalid <= c.dq_rd_oe;
    end
  end
  assign wbeat = wl_line_r[WL-1] || (wcnt_r > 8'h01);
endmodule // dpw_ctl
`default_nettype wire

// ### rtl/dpw_mem.sv
// dpw_mem: memory-side command decode, write masking, precharge and auto-precharge
// assumes the controller honours interrupt and spacing limits; one beat per clock
//
// Contract
// RQ1 - interrupt writes only with burst eight
// RQ2 - only a write may interrupt
// RQ3 - interrupting write exactly two clocks later
// RQ4 - interrupting write may hit any bank
// RQ5 - auto-precharge writes never interrupted
// RQ6 - interrupting write may carry auto-precharge
// RQ7 - spacing uses programmed burst length
// RQ8 - one mask per eight data bits
// RQ9 - mask pin may become read strobe
// RQ10 - decode precharge from control pins
// RQ11 - precharge-all bit selects one or all
// RQ12 - read to precharge at least al+bl/2
// RQ13 - respect active and precharge times
// RQ14 - read to precharge meets trtp
// RQ15 - write to precharge wl+bl/2+twr
// RQ16 - ap bit requests auto-precharge
// RQ17 - read ap starts al+bl/2, postponed if needed
// RQ18 - write ap waits for stored data
// RQ19 - lockout holds ap until tras
// RQ20 - trp from actual internal precharge
// RQ21 - activate after trp and trc
// RQ22 - write latency al+cl-1; extra data ignored
// RQ23 - controller keeps per-bank counters
`timescale 1ns/1ps
`default_nettype none
module dpw_mem import dpw_pkg::*; #(
  parameter int AL = 0,
  parameter int CL = 3,
  parameter int WORDS = 64
) (
  input wire logic clk,
  input wire logic rst,
  dpw_if.mem m,
  input wire logic bl8,
  input wire logic rdqs_en,
  output logic [NUM_BANKS-1:0] bank_open,
  output logic [NUM_BANKS-1:0] bank_pre_busy,
  output logic [NUM_BANKS-1:0] ap_pend
);
  localparam int WL = AL + CL - 1; // see RQ22
  localparam int RL = AL + CL;
  localparam int AW = $clog2(WORDS);
  localparam int SHW = 16;

  logic [3:0] cmd;
  logic is_act, is_rd, is_wr, is_pre;
  logic [DQ_W-1:0] mem_r [WORDS];
  logic [CNT_W-1:0] bl_half;
  assign cmd = {m.cs_n, m.ras_n, m.cas_n, m.we_n};
  assign is_act = (cmd == CMD_ACT);
  assign is_rd = (cmd == CMD_RD);
  assign is_wr = (cmd == CMD_WR);
  assign is_pre = (cmd == CMD_PRE); // see RQ10
  assign bl_half = bl8 ? CNT_W'(BL8 / 2) : CNT_W'(BL4 / 2);

  // ------------------------------------------------------------
  // write data path
  // ------------------------------------------------------------
  // a shift line of write commands lets data arrive WL clocks later
  logic [SHW-1:0] wr_line_r;
  logic [AW-1:0] wr_col_line_r [SHW];
  logic [CNT_W-1:0] beat_r;
  logic [AW-1:0] wcol_r;
  logic wact_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_line_r <= '0;
    end else begin
      wr_line_r <= {wr_line_r[SHW-2:0], is_wr};
    end
  end
  always_ff @(posedge clk) begin
    wr_col_line_r[0] <= AW'(m.addr);
    for (int i = 1; i < SHW; i++) wr_col_line_r[i] <= wr_col_line_r[i-1];
  end
  logic wstart;
  logic [AW-1:0] wstart_col;
  assign wstart = (WL == 0) ? is_wr : wr_line_r[WL-1];
  assign wstart_col = (WL == 0) ? AW'(m.addr) : wr_col_line_r[WL-1];
  // a new write restarts the beat count, cutting the old burst short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      beat_r <= '0;
      wact_r <= 1'b0;
      wcol_r <= '0;
    end else if (wstart) begin // see RQ2 see RQ3 see RQ4
      beat_r <= 8'h01;
      wact_r <= 1'b1;
      wcol_r <= wstart_col;
    end else if (wact_r) begin
      beat_r <= beat_r + 8'h01;
      if (beat_r == (bl_half << 1) - 8'h01) wact_r <= 1'b0; // see RQ22
    end
  end
  logic wbeat;
  logic [AW-1:0] wbeat_col;
  assign wbeat = wstart || wact_r;
  assign wbeat_col = wstart ? wstart_col : AW'(wcol_r + AW'(beat_r));
  always_ff @(posedge clk) begin
    for (int g = 0; g < DM_W; g++) begin
      if (wbeat && !m.dm[g]) begin // see RQ8
        mem_r[wbeat_col][g*8 +: 8] <= m.dq_wr[g*8 +: 8];
      end
    end
  end

  // ------------------------------------------------------------
  // read data path and strobe on the mask pin
  // ------------------------------------------------------------
  logic [SHW-1:0] rd_line_r;
  logic [AW-1:0] rd_col_line_r [SHW];
  logic [CNT_W-1:0] rbeat_r;
  logic [AW-1:0] rcol_r;
  logic ract_r;
  logic [DQ_W-1:0] dq_rd_r;
  logic rstart;
  logic [AW-1:0] rstart_col;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_line_r <= '0;
    end else begin
      rd_line_r <= {rd_line_r[SHW-2:0], is_rd};
    end
  end
  always_ff @(posedge clk) begin
    rd_col_line_r[0] <= AW'(m.addr);
    for (int i = 1; i < SHW; i++) rd_col_line_r[i] <= rd_col_line_r[i-1];
  end
  assign rstart = rd_line_r[RL-1];
  assign rstart_col = rd_col_line_r[RL-1];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rbeat_r <= '0;
      ract_r <= 1'b0;
      rcol_r <= '0;
      dq_rd_r <= '0;
    end else if (rstart) begin
      rbeat_r <= 8'h01;
      ract_r <= 1'b1;
      rcol_r <= rstart_col;
      dq_rd_r <= mem_r[rstart_col];
    end else if (ract_r) begin
      rbeat_r <= rbeat_r + 8'h01;
      dq_rd_r <= mem_r[AW'(rcol_r + AW'(rbeat_r))];
      if (rbeat_r == (bl_half << 1)) ract_r <= 1'b0;
    end
  end
  logic rd_drive;
  assign rd_drive = ract_r && (rbeat_r <= (bl_half << 1));
  assign m.dq_rd = dq_rd_r;
  assign m.dq_rd_oe = rd_drive;
  assign m.rdqs = rd_drive & rbeat_r[0]; // see RQ9
  assign m.rdqs_oe = rd_drive & rdqs_en; // see RQ9

  // ------------------------------------------------------------
  // per-bank state and auto-precharge
  // ------------------------------------------------------------
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    logic hit;
    logic [CNT_W-1:0] ras_r, trp_r, ap_wait_r, rtp_r;
    assign hit = (m.bank == BANK_W'(b));
    // precharge-all ignores the bank bits
    logic pre_now;
    assign pre_now = is_pre && (m.addr[AP_BIT] || hit); // see RQ11
    logic ap_fire;
    assign ap_fire = ap_pend[b] && (ap_wait_r == '0) && (ras_r == '0) && (rtp_r == '0);
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        bank_open[b] <= 1'b0;
        ras_r <= '0;
      end else if (is_act && hit) begin
        bank_open[b] <= 1'b1;
        ras_r <= CNT_W'(TRAS_CK);
      end else begin
        if (ras_r != '0) ras_r <= ras_r - 8'h01;
        if (pre_now || ap_fire) bank_open[b] <= 1'b0; // see RQ10 see RQ19
      end
    end
    // auto-precharge request and its earliest start point
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ap_pend[b] <= 1'b0;
        ap_wait_r <= '0;
        rtp_r <= '0;
      end else if ((is_rd || is_wr) && hit) begin
        ap_pend[b] <= m.addr[AP_BIT]; // see RQ16 see RQ6
        if (is_rd) begin
          // al+bl/2; never before trtp past the last prefetch
          // one less: the start fires on the edge after the count reaches zero
          ap_wait_r <= CNT_W'(AL) + bl_half - 8'h01; // see RQ17 see RQ20
          rtp_r <= CNT_W'(AL) + (bl8 ? CNT_W'(PREFETCH_GAP) : '0) + CNT_W'(TRTP_CK) - 8'h01;
        end else begin
          // last data stored, then write recovery
          // single-rate beats: the burst lasts two clocks per half burst
          ap_wait_r <= CNT_W'(WL) + (bl_half << 1) - 8'h01 + CNT_W'(TWR_CK); // see RQ18 see RQ7
          rtp_r <= '0;
        end
      end else begin
        if (ap_wait_r != '0) ap_wait_r <= ap_wait_r - 8'h01;
        if (rtp_r != '0) rtp_r <= rtp_r - 8'h01;
        if (ap_fire) ap_pend[b] <= 1'b0; // see RQ19
      end
    end
    // precharge time counts from the actual internal start
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        trp_r <= '0;
      end else if (pre_now || ap_fire) begin
        trp_r <= CNT_W'(TRP_CK); // see RQ20
      end else if (trp_r != '0) begin
        trp_r <= trp_r - 8'h01;
      end
    end
    assign bank_pre_busy[b] = (trp_r != '0);
  end
endmodule // dpw_mem
`default_nettype wire

// ### verif/ddr2_precharge_write_interrupt_test.sv
// bench: controller and memory ends joined by dpw_if, checker beside it
// assumes AL=0, CL=3 and the package timing counts
`timescale 1ns/1ps
`default_nettype none
module ddr2_precharge_write_interrupt_test import dpw_pkg::*;;
  localparam int AL_T = 0;
  localparam int CL_T = 3;
  logic clk = 1'b0;
  logic rst, bl8, rdqs_en, req, req_intr, ack, wbeat, rvalid, wb_q;
  logic [3:0] req_cmd, bank_open, bank_pre_busy, ap_pend;
  logic [BANK_W-1:0] req_bank;
  logic [ADDR_W-1:0] req_addr;
  logic [DQ_W-1:0] wdata, rdata;
  logic [DM_W-1:0] wmask;
  logic [DQ_W-1:0] wd [16];
  logic [DM_W-1:0] wm [16];
  logic [DQ_W-1:0] rq [16];
  int k, rn, rs, cyc, failures, total_checks;
  dpw_if f (.clk(clk));
  dpw_ctl #(.AL(AL_T), .CL(CL_T)) i_dpw_ctl (.clk(clk), .rst(rst), .c(f), .bl8(bl8),
    .req(req), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
    .req_intr(req_intr), .ack(ack), .wdata(wdata), .wmask(wmask), .wbeat(wbeat),
    .rdata(rdata), .rvalid(rvalid));
  dpw_mem #(.AL(AL_T), .CL(CL_T)) i_dpw_mem (.clk(clk), .rst(rst), .m(f), .bl8(bl8),
    .rdqs_en(rdqs_en), .bank_open(bank_open), .bank_pre_busy(bank_pre_busy),
    .ap_pend(ap_pend));
  dpw_sva #(.AL(AL_T), .CL(CL_T)) i_dpw_sva (.clk(clk), .rst(rst), .cs_n(f.cs_n),
    .ras_n(f.ras_n), .cas_n(f.cas_n), .we_n(f.we_n), .bank(f.bank), .addr(f.addr),
    .dq_rd_oe(f.dq_rd_oe), .rdqs_oe(f.rdqs_oe));
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // --------------------------------
  // beat feed and read capture
  // --------------------------------
  always @(negedge clk) begin
    wb_q = wbeat;
    if (rvalid === 1'b1 && rn < 16) begin
      rq[rn] = rdata;
      rn++;
    end
    if (f.rdqs_oe === 1'b1) rs++;
  end
  always @(posedge clk) begin
    #1;
    k = (wb_q === 1'b1) ? k + 1 : 0;
    wdata = wd[k % 16];
    wmask = wm[k % 16];
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // holds the request until ack; at is the ack cycle or -1 if refused
  task issue(input logic [3:0] cmd, input int b, input int a, input logic intr,
             input int lim, output int at);
    int n;
    n = 0;
    req = 1'b1;
    req_cmd = cmd;
    req_bank = BANK_W'(b);
    req_addr = ADDR_W'(a);
    req_intr = intr;
    do begin
      @(negedge clk);
      n++;
    end while (ack !== 1'b1 && n < lim);
    at = (ack === 1'b1) ? cyc : -1;
    @(posedge clk);
    #1;
    req = 1'b0;
    req_intr = 1'b0;
    idle(1);
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task s_mask;
    int t;
    bl8 = 1'b0;
    issue(CMD_ACT, 0, 0, 1'b0, 40, t);
    for (int i = 0; i < 4; i++) wd[i] = DQ_W'(8'h10 + i);
    issue(CMD_WR, 0, 0, 1'b0, 40, t);
    idle(10);
    for (int i = 0; i < 4; i++) wd[i] = DQ_W'(8'h20 + i);
    wm[1] = 1'b1;
    issue(CMD_WR, 0, 0, 1'b0, 40, t);
    idle(10);
    rn = 0;
    rdqs_en = 1'b1;
    issue(CMD_RD, 0, 0, 1'b0, 40, t);
    idle(10);
    chk(rn, BL4);
    for (int i = 0; i < 4; i++) chk(rq[i], (i == 1) ? 32'h11 : 32'h20 + i);
    chk(rs != 0, 1);
    chk(bank_open, 4'h1);
    wm[1] = 1'b0;
  endtask
  task s_pre;
    int t;
    logic [3:0] e;
    e = 4'hF;
    for (int b = 1; b < 4; b++) issue(CMD_ACT, b, 0, 1'b0, 40, t);
    for (int b = 0; b < 4; b++) begin
      issue(CMD_PRE, b, 0, 1'b0, 40, t);
      idle(3);
      e[b] = 1'b0;
      chk(bank_open, e);
    end
    for (int b = 0; b < 4; b++) issue(CMD_ACT, b, 0, 1'b0, 40, t);
    issue(CMD_PRE, 2, 1 << AP_BIT, 1'b0, 40, t);
    idle(3);
    chk(bank_open, 4'h0);
  endtask
  task s_intr;
    int t0, t1;
    bl8 = 1'b1;
    for (int i = 0; i < 12; i++) wd[i] = DQ_W'(8'h40 + i);
    issue(CMD_ACT, 0, 0, 1'b0, 40, t0);
    issue(CMD_ACT, 1, 0, 1'b0, 40, t0);
    issue(CMD_WR, 0, 0, 1'b0, 40, t0);
    issue(CMD_WR, 1, (1 << AP_BIT) | 8, 1'b1, 40, t1);
    chk(t1 - t0, INTR_GAP);
    idle(20);
    chk(bank_open, 4'h1);
    rn = 0;
    issue(CMD_RD, 0, 0, 1'b0, 40, t0);
    idle(12);
    chk(rn, BL8);
    for (int i = 0; i < 2; i++) chk(rq[i], 32'h40 + i);
    chk(rq[2], 32'h22);
    chk(rq[3], 32'h23);
  endtask
  task s_rdap;
    int t, n;
    issue(CMD_RD, 0, 1 << AP_BIT, 1'b0, 40, t);
    n = 0;
    while (bank_open[0] === 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(cyc - t, AL_T + BL8 / 2 + 2);
    chk(bank_open, 4'h0);
    idle(2);
  endtask
  task s_refuse;
    int t;
    bl8 = 1'b0;
    issue(CMD_ACT, 0, 0, 1'b0, 40, t);
    issue(CMD_WR, 0, 0, 1'b0, 40, t);
    issue(CMD_WR, 0, 16, 1'b1, 6, t);
    chk(t, 32'hFFFFFFFF);
    idle(10);
    bl8 = 1'b1;
    issue(CMD_WR, 0, 1 << AP_BIT, 1'b0, 40, t);
    issue(CMD_WR, 0, 16, 1'b1, 6, t);
    chk(t, 32'hFFFFFFFF);
    idle(20);
  endtask
  initial begin
    {rst, bl8, rdqs_en, req, req_intr} = 5'h10;
    {req_cmd, req_bank, req_addr, wdata, wmask} = {CMD_NOP, 25'h0};
    k = 0;
    rn = 0;
    rs = 0;
    cyc = 0;
    failures = 0;
    total_checks = 0;
    for (int i = 0; i < 16; i++) {wd[i], wm[i]} = '0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    idle(1);
    s_mask;
    s_pre;
    s_intr;
    s_rdap;
    s_refuse;
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    give_verdict;
  end
endmodule // ddr2_precharge_write_interrupt_test
`default_nettype wire

// ### verif/dpw_sva.sv
// dpw_sva: timing checks on the command link between the two ends
// assumes one clock; sits beside the interface in the bench
`timescale 1ns/1ps
`default_nettype none
module dpw_sva import dpw_pkg::*; #(
  parameter int AL = 0,
  parameter int CL = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_W-1:0] bank,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic dq_rd_oe,
  input wire logic rdqs_oe
);
  localparam int RL = AL + CL;
  localparam int RL1 = RL + 1;
  logic [3:0] cmd;
  logic wr;
  logic rd;
  logic pre;
  logic act;
  logic [2:0] wcnt_r [NUM_BANKS];
  logic [NUM_BANKS-1:0] rbusy_r;
  logic [NUM_BANKS-1:0] wbusy;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign wr = cmd == CMD_WR;
  assign rd = cmd == CMD_RD;
  assign pre = cmd == CMD_PRE;
  assign act = cmd == CMD_ACT;
  // --------------------------------
  // per-bank recovery windows
  // --------------------------------
  always_ff @(posedge clk or posedge rst) begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (rst) begin
        wcnt_r[i] <= 3'h0;
        rbusy_r[i] <= 1'b0;
      end else begin
        rbusy_r[i] <= rd && bank == BANK_W'(i);
        if (wr && bank == BANK_W'(i)) begin
          wcnt_r[i] <= 3'h4;
        end else if (wcnt_r[i] != 3'h0) begin
          wcnt_r[i] <= wcnt_r[i] - 3'h1;
        end
      end
    end
  end
  always_comb begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      wbusy[i] = wcnt_r[i] != 3'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_wr_ccd_min: assert property (wr |=> !wr)
    else $error("write one clock after write");
  a_no_rd_intr: assert property (wr |=> !rd [*4])
    else $error("read cuts into write burst");
  a_wr_pre_gap: assert property (pre |-> (addr[AP_BIT] ? wbusy == '0 : !wbusy[bank]))
    else $error("precharge inside write recovery");
  a_rd_pre_gap: assert property (pre |-> (addr[AP_BIT] ? rbusy_r == '0 : !rbusy_r[bank]))
    else $error("precharge too soon after read");
  a_act_row_cycle: assert property (act |=> !(act && bank == $past(bank)))
    else $error("activate same bank back to back");
  a_rd_latency: assert property (rd |-> ##[RL:RL1] dq_rd_oe)
    else $error("read data late");
  a_oe_has_read: assert property ($rose(dq_rd_oe) |-> $past(rd, RL) || $past(rd, RL1))
    else $error("read data without read");
  a_rdqs_in_read: assert property (rdqs_oe |-> ##[0:1] dq_rd_oe)
    else $error("read strobe outside read");
endmodule // dpw_sva
`default_nettype wire
